// ==== logic/sqs_irq.sv ====
// sticky event status, mask and level interrupt
`timescale 1ns/1ps
`include "sqs_params.svh"
module sqs_irq (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`SQS_NEV-1:0] ev,
  input wire logic wr_stat,
  input wire logic wr_mask,
  input wire logic [`SQS_NEV-1:0] wd,
  output logic [`SQS_NEV-1:0] stat,
  output logic [`SQS_NEV-1:0] mask,
  output logic irq
);
  logic [`SQS_NEV-1:0] stat_next;
  logic [`SQS_NEV-1:0] mask_next;
  logic irq_next;

  // write one clears; a new event in the same cycle wins
  always_comb begin
    stat_next = stat;
    mask_next = mask;
    if (wr_stat) begin
      stat_next = stat & ~wd;
    end
    stat_next = stat_next | ev;
    if (wr_mask) begin
      mask_next = wd;
    end
    irq_next = |(stat_next & mask_next);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat <= 4'h0;
      mask <= 4'h0;
      irq <= 1'b0;
    end else begin
      stat <= stat_next;
      mask <= mask_next;
      irq <= irq_next;
    end
  end

  a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 irq == |($past(stat_next) & $past(mask_next)))
    else $error("irq level does not follow masked status");
endmodule

// ==== logic/sqs_params.svh ====
// constants of the word sequencer step unit
//
// Overview of operation
// RULE1: rising rung sets active flag, advances position
// RULE2: output mode moves masked step word out
// RULE3: mask one passes bit, zero keeps destination
// RULE4: output rewritten on every true scan
// RULE5: done after last word, cleared next rise
// RULE6: completed cycle wraps position back to one
// RULE7: length counts from one, at most 104
// RULE8: run entry at zero: true transfers step zero
// RULE9: bad position or length sets error, minor fault
// RULE10: compare sets match when unmasked bits equal
// RULE11: compare repeated every scan while rung true
// RULE12: mask, source, destination files indexed by position
// RULE13: clear zeroes flags and position, keeps match
// RULE14: load stores word, file entry or constant
// RULE15: load clears active flag when rung falls
// RULE16: load sets done after last word written
// RULE17: three control words: status, length, position
// RULE18: load rewrites source every true scan
// RULE19: rise found against stored previous rung
`ifndef SQS_PARAMS_SVH
`define SQS_PARAMS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SQS_A_STAT 8'h00
`define SQS_A_LEN 8'h04
`define SQS_A_POS 8'h08
`define SQS_A_CFG 8'h0C
`define SQS_A_MASK 8'h10
`define SQS_A_SRC 8'h14
`define SQS_A_DST 8'h18
`define SQS_A_SCAN 8'h1C
`define SQS_A_FSEL 8'h20
`define SQS_A_FDAT 8'h24
`define SQS_A_ISTA 8'h28
`define SQS_A_IMSK 8'h2C
`define SQS_A_MINOR 8'h30
`define SQS_A_NONE 8'hFF
// ----------------------------------------------------------------
// field positions, sizes and limits
// ----------------------------------------------------------------
`define SQS_B_EN 15
`define SQS_B_DONE 13
`define SQS_B_FAULT 11
`define SQS_B_MATCH 8
`define SQS_B_RUNG 0
`define SQS_B_FIRST 1
`define SQS_B_CLR 2
`define SQS_B_MF 2
`define SQS_B_SF 3
`define SQS_B_DF 4
`define SQS_IW 7
`define SQS_DEPTH 105
`define SQS_LAST_IDX 7'h68
`define SQS_MAX_LEN 16'h0068
`define SQS_POS_ONE 16'h0001
`define SQS_NEV 4
`define SQS_HSIZE_WORD 3'h2
`endif

// ==== logic/sqs_pkg.sv ====
// types and shared functions of the word sequencer step unit
package sqs_pkg;
  typedef logic [15:0] sqs_word_t;
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WAIT,
    BUS_DONE
  } sqs_bus_t;
  typedef enum logic [1:0] {
    MODE_OUT,
    MODE_CMP,
    MODE_LOAD,
    MODE_RSVD
  } sqs_mode_t;

  // masked move: set mask bits pass data, clear ones keep old
  function automatic sqs_word_t sqs_merge(input sqs_word_t old,
      input sqs_word_t dat, input sqs_word_t msk);
    sqs_merge = (old & ~msk) | (dat & msk);
  endfunction

  // masked equality of source against reference word
  function automatic logic sqs_meq(input sqs_word_t a,
      input sqs_word_t b, input sqs_word_t msk);
    sqs_meq = ((a ^ b) & msk) == 16'h0000;
  endfunction
endpackage

// ==== logic/sqs_top.sv ====
// word sequencer step unit: AHB-Lite slave and step engine
//
// The AHB-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "sqs_params.svh"
module sqs_top (
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output sqs_pkg::sqs_word_t DEST_OUT,
  output logic IRQ
);
  import sqs_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  sqs_bus_t bus_reg, bus_next;
  logic [7:0] addr_reg, addr_next;
  logic wr_reg, wr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic en_reg, en_next, done_reg, done_next;
  logic fault_reg, fault_next, match_reg, match_next;
  logic minor_reg, minor_next, prev_reg, prev_next;
  sqs_word_t len_reg, len_next, pos_reg, pos_next;
  sqs_word_t mask_reg, mask_next, src_reg, src_next;
  sqs_word_t dst_reg, dst_next;
  logic [4:0] cfg_reg, cfg_next;
  logic [8:0] fsel_reg, fsel_next;
  logic acc, wr_now, rd_now, exec, rung, first, clr, bad, rise, adv;
  sqs_mode_t mode;
  sqs_word_t np, mask_v, src_v, dst_v, stat_w;
  logic [`SQS_IW-1:0] idx, fidx;
  sqs_word_t seq_q, msk_q, src_q, dst_q;
  sqs_word_t seq_b, msk_b, src_b, dst_b;
  logic [3:0] f_we;
  logic [`SQS_IW-1:0] f_wa;
  sqs_word_t f_wd, dfile_wd;
  logic [`SQS_NEV-1:0] ev, istat, imask;
  logic fwr, dfile_we, seq_load;

  // ----------------------------------------------------------------
  // bus slave: each transfer takes one wait state
  // ----------------------------------------------------------------
  // the wait state lets a write land before any read is sampled
  assign acc = HSEL && HREADY && HTRANS[1];
  assign wr_now = (bus_reg == BUS_WAIT) && wr_reg;
  assign rd_now = (bus_reg == BUS_WAIT) && !wr_reg;

  always_comb begin
    bus_next = bus_reg;
    addr_next = addr_reg;
    wr_next = wr_reg;
    case (bus_reg)
      BUS_IDLE, BUS_DONE: begin
        if (acc) begin
          bus_next = BUS_WAIT;
          addr_next = (HADDR[31:8] == 24'h000000) ? HADDR[7:0]
                                                  : `SQS_A_NONE;
          wr_next = HWRITE && (HSIZE == `SQS_HSIZE_WORD);
        end else begin
          bus_next = BUS_IDLE;
        end
      end
      BUS_WAIT: bus_next = BUS_DONE;
      default: bus_next = BUS_IDLE;
    endcase
  end

  // status word layout, other bits read zero
  always_comb begin
    stat_w = 16'h0000;
    stat_w[`SQS_B_EN] = en_reg;
    stat_w[`SQS_B_DONE] = done_reg;
    stat_w[`SQS_B_FAULT] = fault_reg;
    stat_w[`SQS_B_MATCH] = match_reg;
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    rdata_next = rdata_reg;
    if (rd_now) begin
      case (addr_reg)
        `SQS_A_STAT: rdata_next = {16'h0000, stat_w}; // RULE17
        `SQS_A_LEN: rdata_next = {16'h0000, len_reg};
        `SQS_A_POS: rdata_next = {16'h0000, pos_reg};
        `SQS_A_CFG: rdata_next = {27'h0000000, cfg_reg};
        `SQS_A_MASK: rdata_next = {16'h0000, mask_reg};
        `SQS_A_SRC: rdata_next = {16'h0000, src_reg};
        `SQS_A_DST: rdata_next = {16'h0000, dst_reg};
        `SQS_A_FSEL: rdata_next = {23'h000000, fsel_reg};
        `SQS_A_FDAT: begin
          case (fsel_reg[8:7])
            2'h0: rdata_next = {16'h0000, seq_b};
            2'h1: rdata_next = {16'h0000, msk_b};
            2'h2: rdata_next = {16'h0000, src_b};
            default: rdata_next = {16'h0000, dst_b};
          endcase
        end
        `SQS_A_ISTA: rdata_next = {28'h0000000, istat};
        `SQS_A_IMSK: rdata_next = {28'h0000000, imask};
        `SQS_A_MINOR: rdata_next = {31'h00000000, minor_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // scan decode: a write to the scan register is one program scan
  // ----------------------------------------------------------------
  assign exec = wr_now && (addr_reg == `SQS_A_SCAN);
  assign rung = HWDATA[`SQS_B_RUNG];
  assign first = HWDATA[`SQS_B_FIRST];
  assign clr = HWDATA[`SQS_B_CLR];
  assign mode = sqs_mode_t'(cfg_reg[1:0]);
  // negative position, zero or negative or oversize length
  assign bad = pos_reg[15] || len_reg[15] || len_reg == 16'h0000 ||
               len_reg > `SQS_MAX_LEN; // RULE9 RULE7
  // the first scan of a run has no valid previous rung
  assign rise = rung && (first || !prev_reg); // RULE19
  // run entry at position zero with a true rung uses step zero
  assign adv = rise && !(first && pos_reg == 16'h0000); // RULE8
  assign np = !adv ? pos_reg :
              (pos_reg >= len_reg) ? `SQS_POS_ONE : // RULE6
              16'(pos_reg + `SQS_POS_ONE); // RULE1
  assign idx = np[`SQS_IW-1:0];
  assign fidx = fsel_reg[`SQS_IW-1:0];
  // operand files track the sequencer file position
  assign mask_v = cfg_reg[`SQS_B_MF] ? msk_q : mask_reg; // RULE12
  assign src_v = cfg_reg[`SQS_B_SF] ? src_q : src_reg; // RULE12 RULE14
  assign dst_v = cfg_reg[`SQS_B_DF] ? dst_q : dst_reg;
  assign dfile_we = exec && !clr && !bad && rung && mode == MODE_OUT &&
                    cfg_reg[`SQS_B_DF];
  assign dfile_wd = sqs_merge(dst_v, seq_q, mask_v); // RULE3
  assign seq_load = exec && !clr && !bad && rung && mode == MODE_LOAD;
  assign fwr = wr_now && (addr_reg == `SQS_A_FDAT);

  // ----------------------------------------------------------------
  // step engine and registers
  // ----------------------------------------------------------------
  always_comb begin
    en_next = en_reg;
    done_next = done_reg;
    fault_next = fault_reg;
    match_next = match_reg;
    minor_next = minor_reg;
    prev_next = prev_reg;
    len_next = len_reg;
    pos_next = pos_reg;
    mask_next = mask_reg;
    src_next = src_reg;
    dst_next = dst_reg;
    cfg_next = cfg_reg;
    fsel_next = fsel_reg;
    if (wr_now) begin
      case (addr_reg)
        `SQS_A_STAT: begin
          en_next = HWDATA[`SQS_B_EN];
          done_next = HWDATA[`SQS_B_DONE];
          fault_next = HWDATA[`SQS_B_FAULT]; // RULE9
          match_next = HWDATA[`SQS_B_MATCH];
        end
        `SQS_A_LEN: len_next = HWDATA[15:0];
        `SQS_A_POS: pos_next = HWDATA[15:0];
        `SQS_A_CFG: cfg_next = HWDATA[4:0];
        `SQS_A_MASK: mask_next = HWDATA[15:0];
        `SQS_A_SRC: src_next = HWDATA[15:0];
        `SQS_A_DST: dst_next = HWDATA[15:0];
        `SQS_A_FSEL: fsel_next = HWDATA[8:0];
        `SQS_A_MINOR: minor_next = HWDATA[0];
        default: begin
        end
      endcase
    end
    if (exec) begin
      prev_next = rung;
      if (clr) begin
        // match flag is left as it was
        en_next = 1'b0; // RULE13
        done_next = 1'b0;
        fault_next = 1'b0;
        pos_next = 16'h0000;
      end else if (bad) begin
        fault_next = 1'b1; // RULE9
        minor_next = 1'b1;
      end else begin
        pos_next = np;
        if (rise) begin
          en_next = 1'b1; // RULE1
          done_next = 1'b0; // RULE5 RULE16
        end else if (!rung) begin
          en_next = 1'b0; // RULE15
        end
        if (adv && np == len_reg) begin
          done_next = 1'b1; // RULE5 RULE16
        end
        if (rung && mode == MODE_OUT && !cfg_reg[`SQS_B_DF]) begin
          dst_next = sqs_merge(dst_reg, seq_q, mask_v); // RULE2 RULE4
        end
        if (rung && mode == MODE_CMP) begin
          match_next = sqs_meq(src_v, seq_q, mask_v); // RULE10 RULE11
        end
      end
    end
  end

  // file write port: the step engine and the bus never share a cycle
  always_comb begin
    f_we = 4'h0;
    f_wa = idx;
    f_wd = src_v;
    if (seq_load) begin
      f_we[0] = 1'b1; // RULE14 RULE18
    end else if (dfile_we) begin
      f_we[3] = 1'b1; // RULE12
      f_wd = dfile_wd;
    end else if (fwr) begin
      f_we[fsel_reg[8:7]] = 1'b1;
      f_wa = fidx;
      f_wd = HWDATA[15:0];
    end
  end

  // events: step taken, done raised, error raised, match raised
  assign ev = {match_next && !match_reg,
               fault_next && !fault_reg && exec,
               done_next && !done_reg && exec,
               exec && adv && !bad && !clr};

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      bus_reg <= BUS_IDLE;
      addr_reg <= 8'h00;
      wr_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      HREADYOUT <= 1'b1;
      en_reg <= 1'b0;
      done_reg <= 1'b0;
      fault_reg <= 1'b0;
      match_reg <= 1'b0;
      minor_reg <= 1'b0;
      prev_reg <= 1'b0;
      len_reg <= 16'h0000;
      pos_reg <= 16'h0000;
      mask_reg <= 16'h0000;
      src_reg <= 16'h0000;
      dst_reg <= 16'h0000;
      cfg_reg <= 5'h00;
      fsel_reg <= 9'h000;
    end else begin
      bus_reg <= bus_next;
      addr_reg <= addr_next;
      wr_reg <= wr_next;
      rdata_reg <= rdata_next;
      HREADYOUT <= (bus_next != BUS_WAIT);
      en_reg <= en_next;
      done_reg <= done_next;
      fault_reg <= fault_next;
      match_reg <= match_next;
      minor_reg <= minor_next;
      prev_reg <= prev_next;
      len_reg <= len_next;
      pos_reg <= pos_next;
      mask_reg <= mask_next;
      src_reg <= src_next;
      dst_reg <= dst_next;
      cfg_reg <= cfg_next;
      fsel_reg <= fsel_next;
    end
  end

  assign HRDATA = rdata_reg;
  assign HRESP = 1'b0;
  assign DEST_OUT = dst_reg;

  // ----------------------------------------------------------------
  // operand files and interrupt
  // ----------------------------------------------------------------
  sqs_wfile u_seq (.clk(MCLK), .we(f_we[0]), .wa(f_wa), .wd(f_wd),
    .ra(idx), .rb(fidx), .qa(seq_q), .qb(seq_b));
  sqs_wfile u_msk (.clk(MCLK), .we(f_we[1]), .wa(f_wa), .wd(f_wd),
    .ra(idx), .rb(fidx), .qa(msk_q), .qb(msk_b));
  sqs_wfile u_src (.clk(MCLK), .we(f_we[2]), .wa(f_wa), .wd(f_wd),
    .ra(idx), .rb(fidx), .qa(src_q), .qb(src_b));
  sqs_wfile u_dst (.clk(MCLK), .we(f_we[3]), .wa(f_wa), .wd(f_wd),
    .ra(idx), .rb(fidx), .qa(dst_q), .qb(dst_b));

  sqs_irq u_irq (.clk(MCLK), .rst_n(NRST), .ev(ev),
    .wr_stat(wr_now && addr_reg == `SQS_A_ISTA),
    .wr_mask(wr_now && addr_reg == `SQS_A_IMSK),
    .wd(HWDATA[`SQS_NEV-1:0]), .stat(istat), .mask(imask), .irq(IRQ));

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);

  logic ok_scan, meq_exp;
  sqs_word_t mrg_exp;
  assign ok_scan = exec && !clr && !bad;
  assign meq_exp = sqs_meq(src_v, seq_q, mask_v);
  assign mrg_exp = sqs_merge(dst_reg, seq_q, mask_v);

  a_rise_advance: assert property ( // RULE1
    ok_scan && rise && !first && pos_reg < len_reg |=> en_reg &&
    pos_reg == $past(pos_reg) + `SQS_POS_ONE)
    else $error("rising rung did not advance");
  a_wrap_one: assert property ( // RULE6
    ok_scan && adv && pos_reg >= len_reg |=> pos_reg == `SQS_POS_ONE)
    else $error("position did not wrap to one");
  a_done_last: assert property ( // RULE5
    ok_scan && adv && np == len_reg
    |=> done_reg ##1 (done_reg || $past(exec)))
    else $error("done not set on last word");
  a_error_set: assert property ( // RULE9
    exec && !clr && bad
    |=> fault_reg && minor_reg && pos_reg == $past(pos_reg))
    else $error("bad control words not flagged");
  a_clear_keep: assert property ( // RULE13
    exec && clr |=> pos_reg == 16'h0000 && !en_reg && !done_reg &&
    !fault_reg && match_reg == $past(match_reg))
    else $error("control clear wrong");
  a_match_flag: assert property ( // RULE10
    ok_scan && rung && mode == MODE_CMP |=> match_reg == $past(meq_exp))
    else $error("match flag wrong");
  a_out_merge: assert property ( // RULE2
    ok_scan && rung && mode == MODE_OUT && !cfg_reg[`SQS_B_DF]
    |=> DEST_OUT == $past(mrg_exp))
    else $error("destination not masked step word");
  a_load_fall: assert property ( // RULE15
    ok_scan && !rung && mode == MODE_LOAD |=> !en_reg)
    else $error("active flag kept after falling rung");
  a_start_zero: assert property ( // RULE8
    ok_scan && first && rung && pos_reg == 16'h0000
    |=> pos_reg == 16'h0000 && en_reg)
    else $error("startup step zero moved");
  a_bus_wait: assert property (acc && HREADYOUT
    |=> !HREADYOUT ##1 HREADYOUT)
    else $error("bus wait state wrong");

  c_wrap: cover property (ok_scan && adv && pos_reg >= len_reg);
  c_match: cover property (ok_scan && mode == MODE_CMP && meq_exp);
  c_load: cover property (seq_load ##[1:20] seq_load);
  c_error: cover property (exec && bad);
endmodule

// ==== logic/sqs_wfile.sv ====
// word file of one sequencer operand, one write and two read ports
`timescale 1ns/1ps
`include "sqs_params.svh"
module sqs_wfile (
  input wire logic clk,
  input wire logic we,
  input wire logic [`SQS_IW-1:0] wa,
  input wire logic [15:0] wd,
  input wire logic [`SQS_IW-1:0] ra,
  input wire logic [`SQS_IW-1:0] rb,
  output logic [15:0] qa,
  output logic [15:0] qb
);
  logic [15:0] mem [0:`SQS_DEPTH-1];

  // writes past the last step are dropped, such reads give zero
  always_ff @(posedge clk) begin
    if (we && wa <= `SQS_LAST_IDX) begin
      mem[wa] <= wd;
    end
  end

  assign qa = (ra <= `SQS_LAST_IDX) ? mem[ra] : 16'h0000;
  assign qb = (rb <= `SQS_LAST_IDX) ? mem[rb] : 16'h0000;
endmodule

// ==== verification/sqs_prog_model.sv ====
// program scan model: AHB-Lite master that issues register accesses
`timescale 1ns/1ps
module sqs_prog_model (
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // ----------------------------------------------------------------
  // idle bus at time zero
  // ----------------------------------------------------------------
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // ----------------------------------------------------------------
  // one single word transfer, address phase then data phase
  // ----------------------------------------------------------------
  // released lines show the inverse so stale values never match
  task automatic xfer(input logic w, input logic [31:0] a,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    haddr <= ~a;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
    hwdata <= ~d;
  endtask
endmodule

// ==== verification/testbench.sv ====
// self-checking bench of the word sequencer step unit
`timescale 1ns/1ps
`include "sqs_params.svh"
module testbench;
  import sqs_pkg::*;
  logic mclk;
  logic nrst;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  sqs_word_t dest_out;
  logic irq;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  int p;
  logic [15:0] exp_d;

  sqs_top u_dut (.MCLK(mclk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .DEST_OUT(dest_out), .IRQ(irq));

  sqs_prog_model u_prog (.clk(mclk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));

  // ----------------------------------------------------------------
  // clock, reset and hang guard
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // about 130 transfers fit well inside this ceiling
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_prog.xfer(1'b1, {24'h0, a}, d, q);
  endtask

  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    u_prog.xfer(1'b0, {24'h0, a}, 32'h0, q);
    cmp(q, e);
  endtask

  // one program scan: bit0 rung, bit1 first scan, bit2 clear
  task automatic scan(input logic [2:0] f);
    wr(`SQS_A_SCAN, {29'h0, f});
  endtask

  task automatic fsel(input logic [1:0] fl, input logic [6:0] i);
    wr(`SQS_A_FSEL, {23'h0, fl, i});
  endtask

  task automatic dchk(input logic [15:0] e);
    chk(`SQS_A_DST, {16'h0, e});
    cmp({16'h0, dest_out}, {16'h0, e});
  endtask

  // masked move worked out independently of the design
  function automatic logic [15:0] mrg(input logic [15:0] o,
      input logic [15:0] d, input logic [15:0] m);
    mrg = (o & ~m) | (d & m);
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    chk(`SQS_A_STAT, 32'h0);
    chk(`SQS_A_LEN, 32'h0);
    chk(`SQS_A_POS, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    cmp({31'h0, hresp}, 32'h0);
    wr(8'h40, 32'h1234);
    chk(8'h40, 32'h0);
    $display("test reset done");

    // output mode: startup step, stepping, done and wrap
    wr(`SQS_A_LEN, 32'h3);
    for (int i = 0; i < 4; i++) begin
      fsel(2'h0, 7'(i));
      wr(`SQS_A_FDAT, {16'h0, {4{4'(i + 1)}}});
    end
    wr(`SQS_A_MASK, 32'h0F0F);
    wr(`SQS_A_DST, 32'hA0A0);
    wr(`SQS_A_CFG, 32'h0);
    scan(3'b011);
    exp_d = mrg(16'hA0A0, 16'h1111, 16'h0F0F);
    dchk(exp_d);
    chk(`SQS_A_POS, 32'h0);
    for (int s = 1; s <= 4; s++) begin
      p = (s > 3) ? 1 : s;
      scan(3'b000);
      scan(3'b001);
      exp_d = mrg(exp_d, {4{4'(p + 1)}}, 16'h0F0F);
      dchk(exp_d);
      chk(`SQS_A_POS, 32'(p));
      chk(`SQS_A_STAT, (p == 3) ? 32'hA000 : 32'h8000);
    end
    wr(`SQS_A_DST, 32'h0);
    scan(3'b001);
    dchk(16'h0202);
    chk(`SQS_A_POS, 32'h1);
    $display("test output done");

    // compare mode: repeated masked compare, then control clear
    wr(`SQS_A_CFG, 32'h1);
    wr(`SQS_A_MASK, 32'h00FF);
    wr(`SQS_A_SRC, 32'h0022);
    scan(3'b001);
    chk(`SQS_A_STAT, 32'h8100);
    wr(`SQS_A_SRC, 32'h0023);
    scan(3'b001);
    chk(`SQS_A_STAT, 32'h8000);
    wr(`SQS_A_SRC, 32'hFF22);
    scan(3'b001);
    chk(`SQS_A_STAT, 32'h8100);
    scan(3'b000);
    scan(3'b001);
    chk(`SQS_A_STAT, 32'h8000);
    wr(`SQS_A_SRC, 32'h0033);
    scan(3'b001);
    chk(`SQS_A_STAT, 32'h8100);
    scan(3'b100);
    chk(`SQS_A_STAT, 32'h0100);
    chk(`SQS_A_POS, 32'h0);
    $display("test compare done");

    // load mode: constant at the signed limit, rewrite, fall, file source
    wr(`SQS_A_CFG, 32'h2);
    wr(`SQS_A_LEN, 32'h2);
    wr(`SQS_A_SRC, 32'h8000);
    scan(3'b001);
    chk(`SQS_A_POS, 32'h1);
    fsel(2'h0, 7'h1);
    chk(`SQS_A_FDAT, 32'h8000);
    wr(`SQS_A_SRC, 32'h7FFF);
    scan(3'b001);
    chk(`SQS_A_FDAT, 32'h7FFF);
    scan(3'b000);
    chk(`SQS_A_STAT, 32'h0100);
    scan(3'b001);
    chk(`SQS_A_STAT, 32'hA100);
    fsel(2'h0, 7'h2);
    chk(`SQS_A_FDAT, 32'h7FFF);
    wr(`SQS_A_CFG, 32'hA);
    fsel(2'h2, 7'h1);
    wr(`SQS_A_FDAT, 32'h1234);
    scan(3'b000);
    scan(3'b001);
    fsel(2'h0, 7'h1);
    chk(`SQS_A_FDAT, 32'h1234);
    chk(`SQS_A_STAT, 32'h8100);
    $display("test load done");

    // operand files: mask and destination files, then source file compare
    wr(`SQS_A_CFG, 32'h14);
    fsel(2'h1, 7'h2);
    wr(`SQS_A_FDAT, 32'hFF00);
    fsel(2'h3, 7'h2);
    wr(`SQS_A_FDAT, 32'h5555);
    scan(3'b000);
    scan(3'b001);
    chk(`SQS_A_FDAT, 32'h7F55);
    dchk(16'h0202);
    chk(`SQS_A_STAT, 32'hA100);
    wr(`SQS_A_CFG, 32'h9);
    fsel(2'h2, 7'h2);
    wr(`SQS_A_FDAT, 32'h12FE);
    scan(3'b001);
    chk(`SQS_A_STAT, 32'hA000);
    wr(`SQS_A_FDAT, 32'h12FF);
    scan(3'b001);
    chk(`SQS_A_STAT, 32'hA100);
    // run entry with a false rung waits, then takes step one
    scan(3'b100);
    scan(3'b010);
    chk(`SQS_A_POS, 32'h0);
    scan(3'b001);
    chk(`SQS_A_POS, 32'h1);
    chk(`SQS_A_STAT, 32'h8100);
    $display("test files done");

    // error flags and the interrupt path
    wr(`SQS_A_ISTA, 32'hF);
    chk(`SQS_A_ISTA, 32'h0);
    wr(`SQS_A_LEN, 32'h0);
    scan(3'b001);
    chk(`SQS_A_STAT, 32'h8900);
    chk(`SQS_A_MINOR, 32'h1);
    chk(`SQS_A_ISTA, 32'h4);
    cmp({31'h0, irq}, 32'h0);
    wr(`SQS_A_IMSK, 32'h4);
    repeat (2) @(posedge mclk);
    cmp({31'h0, irq}, 32'h1);
    wr(`SQS_A_ISTA, 32'h4);
    repeat (2) @(posedge mclk);
    cmp({31'h0, irq}, 32'h0);
    wr(`SQS_A_LEN, 32'h3);
    scan(3'b000);
    chk(`SQS_A_STAT, 32'h0900);
    wr(`SQS_A_STAT, 32'h0);
    wr(`SQS_A_MINOR, 32'h0);
    chk(`SQS_A_MINOR, 32'h0);
    wr(`SQS_A_LEN, 32'h69);
    scan(3'b000);
    chk(`SQS_A_STAT, 32'h0800);
    $display("test error done");
    wrap_up();
  end
endmodule
